// ### hw/spr_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the paged serial register port
// Assumes: 8-bit registers, 8-bit addresses, 17-bit frames
// Notes:   constants only
`ifndef SPR_DEFS_SVH
`define SPR_DEFS_SVH

`define SPR_FRAME_BITS        17
// shared page
`define SPR_ADDR_INIT_CTRL    8'h_e2
`define SPR_ADDR_REVISION     8'h_f0
`define SPR_ADDR_PART_CODE    8'h_f1
`define SPR_ADDR_PAGE_CTRL    8'h_ff
`define SPR_RST_INIT_CTRL     8'h_10
`define SPR_RST_PAGE_CTRL     8'h_00
`define SPR_BIT_INIT_START    0
`define SPR_BIT_INIT_DONE     4
`define SPR_BIT_PAGE_EN       2
`define SPR_PAGE_RECOVERY     2'h_0
`define SPR_PAGE_CABLE        2'h_1
`define SPR_LOCK_RECLOCK      2'h_0
`define SPR_LOCK_COMBINE      2'h_1
`define SPR_LOCK_LOSS         2'h_2
`define SPR_LOCK_IRQ          2'h_3
// recovery page
`define SPR_ADDR_SOFT_RESET   8'h_00
`define SPR_ADDR_LOSS_STATUS  8'h_01
`define SPR_ADDR_STATUS_VIEW  8'h_02
`define SPR_ADDR_BOOST        8'h_03
`define SPR_ADDR_MUX_OVR      8'h_09
`define SPR_ADDR_RCV_RESET    8'h_0a
`define SPR_ADDR_VIEW_SEL     8'h_0c
`define SPR_ADDR_EYE_RANGE    8'h_11
`define SPR_ADDR_EQ_CTRL      8'h_13
`define SPR_ADDR_BOOST_OVR    8'h_2d
`define SPR_RST_SOFT_RESET    8'h_00
`define SPR_RST_BOOST         8'h_80
`define SPR_RST_MUX_OVR       8'h_00
`define SPR_RST_RCV_RESET     8'h_50
`define SPR_RST_VIEW_SEL      8'h_08
`define SPR_RST_EYE_RANGE     8'h_e0
`define SPR_RST_EQ_CTRL       8'h_90
`define SPR_RST_BOOST_OVR     8'h_00
`define SPR_BIT_SOFT_RESET    2
`define SPR_BIT_LOSS          1
`define SPR_BIT_BOOST_OVR     3
`define SPR_BIT_MUX_OVR       5
`define SPR_BIT_RCV_OVR       3
`define SPR_BIT_RCV_RST       2
`define SPR_BIT_EYE_PD        5
`define SPR_BIT_EQ_PD         3
`define SPR_BIT_LATE_BYPASS   1
// initialisation sequence length in system clocks
`define SPR_INIT_CYCLES       8'h_10

`endif

// ### hw/spr_pkg.sv
// Purpose: types of the paged serial register port
// Assumes: spr_defs.svh holds the numbers
// Notes:   types only
package spr_pkg;
  typedef struct packed {
    logic       sck;
    logic       ss_n;
    logic       mosi;
  } spr_link_in_t;

  typedef struct packed {
    logic       miso;
    logic       miso_oe;
  } spr_link_out_t;

  typedef struct packed {
    logic [7:0] boost;
    logic       boost_override;
    logic       mux_individual;
    logic [1:0] shared_out_sel;
    logic       recovery_reset;
    logic [1:0] eye_step;
    logic       eye_monitor_power_down;
    logic       trace_eq_power_down;
    logic       late_stage_bypass;
  } spr_ctrl_t;

  typedef struct packed {
    logic       reclock_lock;
    logic       cable_status;
    logic       sel_input_loss;
    logic       irq_masked;
    logic       trace_input_signal_loss;
    logic [7:0] status_view;
  } spr_stat_t;

  typedef enum logic [1:0] {
    SPR_IDLE,
    SPR_SHIFT,
    SPR_INIT
  } spr_state_t;
endpackage : spr_pkg

// ### hw/spr_port.sv
// Purpose: serial slave port and paged register bank of the equalizer/reclocker
// Assumes: serial pins are asynchronous to clk_sys and slow against it
// Notes:   one chain stage is exactly one 17-bit shift register
`timescale 1ns/1ps
`default_nettype none
`include "spr_defs.svh"

module spr_port
  import spr_pkg::*;
#(
  parameter logic [7:0] REVISION_CODE = 8'h_0005,   // arbitrary value
  parameter logic [7:0] PART_CODE     = 8'h_005a    // arbitrary value
) (
  input  wire logic          clk_sys,
  input  wire logic          sys_rst,
  input  wire logic          clk_en,
  input  wire spr_link_in_t  link_in,
  output spr_link_out_t      link_out,
  input  wire spr_stat_t     stat_in,
  output spr_ctrl_t          ctrl_out,
  output logic               lock_out,
  output logic               init_busy
);

  // ==========================================================
  // pin synchronisers
  logic [2:0] sync1_q;
  logic [2:0] sync2_q;
  logic       sck_prev_q;
  logic       ss_prev_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sync1_q    <= 3'h_7;
      sync2_q    <= 3'h_7;
      sck_prev_q <= 1'b1;
      ss_prev_q  <= 1'b1;
    end else if (clk_en) begin
      sync1_q    <= {link_in.sck, link_in.ss_n, link_in.mosi};
      sync2_q    <= sync1_q;
      sck_prev_q <= sync2_q[2];
      ss_prev_q  <= sync2_q[1];
    end
  end

  logic sck_s, ss_s, mosi_s;
  assign sck_s  = sync2_q[2];
  assign ss_s   = sync2_q[1];
  assign mosi_s = sync2_q[0];

  logic sck_rise, ss_rise, ss_fall;
  assign sck_rise = clk_en && sck_s && !sck_prev_q && !ss_s;
  assign ss_rise  = clk_en && ss_s && !ss_prev_q;
  assign ss_fall  = clk_en && !ss_s && ss_prev_q;

  // ==========================================================
  // shift register and frame counter
  logic [16:0] shift_q;
  logic [7:0]  count_q;
  logic [7:0]  read_addr_q;
  logic [7:0]  rd_data;
  spr_state_t  state_q;

  logic frame_ok, frame_write, frame_read;
  // only a full 17-bit frame acts
  assign frame_ok    = ss_rise && (count_q == 8'(`SPR_FRAME_BITS));
  assign frame_write = frame_ok && !shift_q[16];
  assign frame_read  = frame_ok && shift_q[16];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      count_q <= 8'h_00;
    end else if (ss_fall) begin
      count_q <= 8'h_00;
    end else if (sck_rise && count_q != 8'h_ff) begin
      count_q <= count_q + 8'h_01;
    end
  end

  // the read mux looks at the latched address, so the result is loaded one clock
  // after the address is taken; the next frame cannot start within that clock
  logic rd_load_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      rd_load_q <= 1'b0;
    end else if (clk_en) begin
      rd_load_q <= frame_read;
    end
  end

  // shift register holds the outgoing bit in its msb; the incoming bit enters at
  // the lsb, so a chained neighbour sees this frame one full frame later
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      shift_q <= 17'h_0_0000;
    end else if (rd_load_q && clk_en) begin
      // address then data for the next frame
      shift_q <= {1'b1, read_addr_q, rd_data};
    end else if (sck_rise) begin
      shift_q <= {shift_q[15:0], mosi_s};
    end
  end

  // data bits of the address frame are dropped
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      read_addr_q <= 8'h_00;
    end else if (frame_read) begin
      read_addr_q <= shift_q[15:8];
    end
  end

  // output presents the held shift register msb
  // chained devices relay through this one register
  logic miso_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      miso_q <= 1'b0;
    end else if (clk_en) begin
      miso_q <= shift_q[16];
    end
  end

  assign link_out.miso    = miso_q;
  assign link_out.miso_oe = !ss_s;

  // ==========================================================
  // registers
  logic [7:0] init_ctrl_q;
  logic [7:0] page_ctrl_q;
  logic [7:0] soft_reset_q;
  logic [7:0] boost_q;
  logic [7:0] mux_ovr_q;
  logic [7:0] rcv_reset_q;
  logic [7:0] view_sel_q;
  logic [7:0] eye_range_q;
  logic [7:0] eq_ctrl_q;
  logic [7:0] boost_ovr_q;
  logic       init_done_q;
  logic [7:0] init_cnt_q;

  logic [7:0] wr_addr, wr_data;
  assign wr_addr = shift_q[15:8];
  assign wr_data = shift_q[7:0];

  logic on_shared, on_recovery;
  // page routing; invalid selectors reach nothing
  assign on_shared   = !page_ctrl_q[`SPR_BIT_PAGE_EN];
  assign on_recovery = page_ctrl_q[`SPR_BIT_PAGE_EN] && page_ctrl_q[1:0] == `SPR_PAGE_RECOVERY;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return frame_write && a == b;
  endfunction

  logic page_wr;
  assign page_wr = hit(wr_addr, `SPR_ADDR_PAGE_CTRL);

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      page_ctrl_q <= `SPR_RST_PAGE_CTRL;
    end else if (page_wr) begin
      page_ctrl_q <= wr_data;
    end
  end

  logic sh_wr, rc_wr, page_reset;
  assign sh_wr = on_shared && !page_wr;
  assign rc_wr = on_recovery && !page_wr;
  // self-clearing page reset
  // gated by the clock enable so that a frozen block keeps its page contents
  assign page_reset = soft_reset_q[`SPR_BIT_SOFT_RESET] && clk_en;

  always_ff @(posedge clk_sys) begin
    if (sys_rst || page_reset) begin
      soft_reset_q <= `SPR_RST_SOFT_RESET;
      boost_q      <= `SPR_RST_BOOST;
      mux_ovr_q    <= `SPR_RST_MUX_OVR;
      rcv_reset_q  <= `SPR_RST_RCV_RESET;
      view_sel_q   <= `SPR_RST_VIEW_SEL;
      eye_range_q  <= `SPR_RST_EYE_RANGE;
      eq_ctrl_q    <= `SPR_RST_EQ_CTRL;
      boost_ovr_q  <= `SPR_RST_BOOST_OVR;
    end else if (rc_wr) begin
      if (hit(wr_addr, `SPR_ADDR_SOFT_RESET)) soft_reset_q <= wr_data;
      if (hit(wr_addr, `SPR_ADDR_BOOST))      boost_q      <= wr_data;
      if (hit(wr_addr, `SPR_ADDR_MUX_OVR))    mux_ovr_q    <= wr_data;
      if (hit(wr_addr, `SPR_ADDR_RCV_RESET))  rcv_reset_q  <= wr_data;
      if (hit(wr_addr, `SPR_ADDR_VIEW_SEL))   view_sel_q   <= wr_data;
      if (hit(wr_addr, `SPR_ADDR_EYE_RANGE))  eye_range_q  <= wr_data;
      if (hit(wr_addr, `SPR_ADDR_EQ_CTRL))    eq_ctrl_q    <= wr_data;
      if (hit(wr_addr, `SPR_ADDR_BOOST_OVR))  boost_ovr_q  <= wr_data;
    end
  end

  // ==========================================================
  // initialisation sequence
  // the sequence only counts; the registers it would load are outside this block,
  // so software sees the done bit fall and rise again after a fixed time
  logic init_start;
  // bit 0 starts, done bit reads back
  assign init_start = sh_wr && hit(wr_addr, `SPR_ADDR_INIT_CTRL) && wr_data[`SPR_BIT_INIT_START];

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      init_ctrl_q <= `SPR_RST_INIT_CTRL;
    end else if (sh_wr && hit(wr_addr, `SPR_ADDR_INIT_CTRL)) begin
      init_ctrl_q <= {3'h_0, 1'b0, wr_data[3:0]};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      state_q     <= SPR_IDLE;
      init_cnt_q  <= 8'h_00;
      init_done_q <= 1'b1;
    end else if (clk_en) begin
      unique case (state_q)
        SPR_IDLE, SPR_SHIFT: begin
          state_q <= ss_s ? SPR_IDLE : SPR_SHIFT;
          if (init_start) begin
            state_q     <= SPR_INIT;
            init_cnt_q  <= `SPR_INIT_CYCLES;
            init_done_q <= 1'b0;
          end
        end
        SPR_INIT: begin
          init_cnt_q <= init_cnt_q - 8'h_01;
          if (init_cnt_q == 8'h_01) begin
            state_q     <= SPR_IDLE;
            init_done_q <= 1'b1;
          end
        end
      endcase
    end
  end
  assign init_busy = state_q == SPR_INIT;

  // ==========================================================
  // read mux
  // addresses with no register read zero; the cable page is not held here,
  // so a read there returns zero as well, except at 0xff
  always_comb begin
    rd_data = 8'h_00;
    if (read_addr_q == `SPR_ADDR_PAGE_CTRL) begin
      // 0xff reads page control on every page
      rd_data = page_ctrl_q;
    end else if (on_shared) begin
      unique case (read_addr_q)
        `SPR_ADDR_INIT_CTRL: rd_data = {init_ctrl_q[7:5], init_done_q, init_ctrl_q[3:0]};
        `SPR_ADDR_REVISION:  rd_data = REVISION_CODE;
        `SPR_ADDR_PART_CODE: rd_data = PART_CODE;
        default:             rd_data = 8'h_00;
      endcase
    end else if (on_recovery) begin
      unique case (read_addr_q)
        `SPR_ADDR_SOFT_RESET:  rd_data = soft_reset_q;
        `SPR_ADDR_LOSS_STATUS: rd_data = {6'h_00, stat_in.trace_input_signal_loss, 1'b1};
        `SPR_ADDR_STATUS_VIEW: rd_data = stat_in.status_view;
        `SPR_ADDR_BOOST:       rd_data = boost_q;
        `SPR_ADDR_MUX_OVR:     rd_data = mux_ovr_q;
        `SPR_ADDR_RCV_RESET:   rd_data = rcv_reset_q;
        `SPR_ADDR_VIEW_SEL:    rd_data = view_sel_q;
        `SPR_ADDR_EYE_RANGE:   rd_data = eye_range_q;
        `SPR_ADDR_EQ_CTRL:     rd_data = eq_ctrl_q;
        `SPR_ADDR_BOOST_OVR:   rd_data = boost_ovr_q;
        default:               rd_data = 8'h_00;
      endcase
    end
  end

  // ==========================================================
  // control outputs
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ctrl_out <= '0;
    end else if (clk_en) begin
      ctrl_out.boost                  <= boost_q;
      ctrl_out.boost_override         <= boost_ovr_q[`SPR_BIT_BOOST_OVR];
      ctrl_out.mux_individual         <= mux_ovr_q[`SPR_BIT_MUX_OVR];
      ctrl_out.shared_out_sel         <= 2'h_2;
      ctrl_out.recovery_reset         <= rcv_reset_q[`SPR_BIT_RCV_OVR] && rcv_reset_q[`SPR_BIT_RCV_RST];
      ctrl_out.eye_step               <= eye_range_q[7:6];
      ctrl_out.eye_monitor_power_down <= eye_range_q[`SPR_BIT_EYE_PD];
      ctrl_out.trace_eq_power_down    <= eq_ctrl_q[`SPR_BIT_EQ_PD];
      ctrl_out.late_stage_bypass      <= eq_ctrl_q[`SPR_BIT_LATE_BYPASS];
    end
  end

  // lock pin function
  // status inputs share this clock, so they need no synchroniser here
  logic lock_d;
  always_comb begin
    lock_d = stat_in.reclock_lock;
    unique case (page_ctrl_q[5:4])
      `SPR_LOCK_RECLOCK: lock_d = stat_in.reclock_lock;
      `SPR_LOCK_COMBINE: begin
        unique case (page_ctrl_q[7:6])
          2'h_0: lock_d = stat_in.reclock_lock;
          2'h_1: lock_d = stat_in.cable_status;
          2'h_2: lock_d = stat_in.reclock_lock | stat_in.cable_status;
          2'h_3: lock_d = stat_in.reclock_lock & stat_in.cable_status;
        endcase
      end
      `SPR_LOCK_LOSS:    lock_d = stat_in.sel_input_loss;
      `SPR_LOCK_IRQ:     lock_d = stat_in.irq_masked;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      lock_out <= 1'b0;
    end else if (clk_en) begin
      lock_out <= lock_d;
    end
  end

endmodule : spr_port
`default_nettype wire

// ### tb/spr_host.sv
// Purpose: host serial master in front of the register port
// Assumes: one device on the chain
// Notes:   serial clock idles low between frames
`timescale 1ns/1ps
`default_nettype none
module spr_host
  import spr_pkg::*;
(
  input  wire logic          clk_sys,
  output wire spr_link_in_t  link_in,
  input  wire spr_link_out_t link_out
);
  logic sck_q = 1'b0;
  logic ss_q  = 1'b1;
  logic bit_q = 1'b0;
  logic pat_q = 1'b0;
  // ==========
  // pins
  // idle data toggles
  always @(posedge clk_sys) pat_q <= ~pat_q;
  assign link_in = '{sck: sck_q, ss_n: ss_q, mosi: ss_q ? pat_q : bit_q};
  // ==========
  // frame
  // msb first, n clocks per select
  task automatic frame(input int n, input logic [16:0] tx, output logic [16:0] rx);
    rx = '0;
    @(posedge clk_sys);
    ss_q <= 1'b0;
    for (int i = 16; i > 16 - n; i--) begin
      @(posedge clk_sys);
      sck_q <= 1'b0;
      bit_q <= tx[i];
      repeat (4) @(posedge clk_sys);
      rx = {rx[15:0], link_out.miso};
      sck_q <= 1'b1;
      repeat (3) @(posedge clk_sys);
    end
    @(posedge clk_sys);
    sck_q <= 1'b0;
    repeat (4) @(posedge clk_sys);
    ss_q <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask : frame
endmodule : spr_host
`default_nettype wire

// ### tb/spr_port_properties.sv
// Purpose: port properties of spr_port
// Assumes: clk_en held high
// Notes:   attached by the bind below the module
`timescale 1ns/1ps
`default_nettype none
module spr_port_chk
  import spr_pkg::*;
(
  input wire logic          clk_sys,
  input wire logic          sys_rst,
  input wire spr_link_in_t  link_in,
  input wire spr_link_out_t link_out,
  input wire spr_ctrl_t     ctrl_out,
  input wire logic          lock_out,
  input wire logic          init_busy
);
  // ==========
  // properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  a_out_released: assert property (link_in.ss_n [*3] |-> !link_out.miso_oe)
    else $error("data out driven while deselected");
  a_out_enabled: assert property (!link_in.ss_n [*3] |-> link_out.miso_oe)
    else $error("data out not driven while selected");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=>
    ctrl_out == '0 && !lock_out && !link_out.miso_oe && !link_out.miso)
    else $error("outputs active in reset");
  a_mux_shared: assert property (!$past(sys_rst) |-> ctrl_out.shared_out_sel == 2'h2)
    else $error("shared output select wrong");
  a_miso_hold: assert property (($stable(link_in.sck) && $stable(link_in.ss_n)) [*6] |-> $stable(link_out.miso))
    else $error("data out moved without serial clock");
  a_init_length: assert property ($rose(init_busy) |-> init_busy [*8] ##[6:10] !init_busy)
    else $error("initialisation length wrong");
  a_init_cause: assert property ($rose(init_busy) |-> $past(link_in.ss_n, 2) && $past(link_in.ss_n, 3))
    else $error("initialisation started inside a frame");
  a_ctrl_cause: assert property (!$past(sys_rst) && !$stable(ctrl_out) |-> $past(link_in.ss_n, 2))
    else $error("control changed inside a frame");
endmodule : spr_port_chk

bind spr_port spr_port_chk chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .link_in(link_in), .link_out(link_out),
  .ctrl_out(ctrl_out), .lock_out(lock_out), .init_busy(init_busy));
`default_nettype wire

// ### tb/spr_port_tb.sv
// Purpose: self-checking bench of the paged serial register port
// Assumes: clk_en held high
// Notes:   recovery page contents kept in an associative model
`timescale 1ns/1ps
`default_nettype none
module spr_port_tb;
  import spr_pkg::*;
  localparam logic [7:0] REV  = 8'h3c;  // arbitrary value
  localparam logic [7:0] PART = 8'ha7;  // arbitrary value
  logic              clk_sys      = 1'b0;
  logic              sys_rst      = 1'b1;
  logic              clk_en       = 1'b1;
  spr_stat_t         stat_in      = '0;
  wire spr_link_in_t link_in;
  spr_link_out_t     link_out;
  spr_ctrl_t         ctrl_out;
  logic              lock_out;
  logic              init_busy;
  int                num_errors   = 0;
  int                total_checks = 0;
  int                rec[int];
  logic [7:0]        d;
  logic [16:0]       rx;

  always #50 clk_sys = ~clk_sys;

  spr_port #(.REVISION_CODE(REV), .PART_CODE(PART)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst), .clk_en(clk_en),
    .link_in(link_in), .link_out(link_out), .stat_in(stat_in), .ctrl_out(ctrl_out), .lock_out(lock_out),
    .init_busy(init_busy));
  spr_host host_u (.clk_sys(clk_sys), .link_in(link_in), .link_out(link_out));

  // ==========
  // model and helpers
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [17:0] got, input logic [17:0] exp, input string msg);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic mreset();
    rec = '{'h00: 0, 'h03: 'h80, 'h09: 0, 'h0a: 'h50, 'h0c: 'h08, 'h11: 'he0, 'h13: 'h90, 'h2d: 0};
  endtask : mreset

  function automatic spr_ctrl_t ctl();
    return '{boost: 8'(rec['h03]), boost_override: rec['h2d][3], mux_individual: rec['h09][5],
      shared_out_sel: 2'h2, recovery_reset: rec['h0a][3] & rec['h0a][2], eye_step: 2'(rec['h11] >> 6),
      eye_monitor_power_down: rec['h11][5], trace_eq_power_down: rec['h13][3], late_stage_bypass: rec['h13][1]};
  endfunction : ctl

  function automatic logic lk(logic [7:0] f, spr_stat_t s);
    logic [3:0] c = {s.reclock_lock & s.cable_status, s.reclock_lock | s.cable_status, s.cable_status, s.reclock_lock};
    logic [3:0] m = {s.irq_masked, s.sel_input_loss, c[f[7:6]], s.reclock_lock};
    return m[f[5:4]];
  endfunction : lk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    host_u.frame(17, {1'b0, a, v}, rx);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    host_u.frame(17, {1'b1, a, 8'hff}, rx);
    host_u.frame(17, {1'b1, 8'hff, 8'hff}, rx);
    chk(18'(rx[16:8]), 18'({1'b1, a}), "read echo");
    v = rx[7:0];
  endtask : rd

  task automatic rall();
    foreach (rec[a]) begin
      rd(8'(a), d);
      chk(18'(d), 18'(rec[a]), "page reg");
    end
    chk(18'(ctrl_out), 18'(ctl()), "controls");
  endtask : rall

  task automatic wt(input logic v);
    for (int i = 0; i < 40 && init_busy !== v; i++) @(posedge clk_sys);
    chk(18'(init_busy), 18'(v), "init busy");
    if (init_busy !== v) print_verdict();
  endtask : wt

  // ==========
  // sequence
  initial begin
    repeat (100000) @(posedge clk_sys);
    num_errors++;
    $display("wrong value at %0t: run too long", $time);
    print_verdict();
  end

  initial begin
    void'($urandom(94));
    mreset();
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(8'he2, d);
    chk(18'(d), 18'h10, "init reg");
    rd(8'hf0, d);
    chk(18'(d), 18'(REV), "revision");
    rd(8'hf1, d);
    chk(18'(d), 18'(PART), "part code");
    rd(8'hff, d);
    chk(18'(d), 18'h0, "page reg");
    wr(8'hff, 8'h04);
    rall();
    $display("test defaults done");
    foreach (rec[a]) if (a != 0) rec[a] = $urandom & 'hff;
    foreach (rec[a]) wr(8'(a), 8'(rec[a]));
    wr(8'h01, 8'hfc);
    host_u.frame(16, {1'b0, 8'h03, ~8'(rec['h03])}, rx);
    stat_in <= spr_stat_t'($urandom);
    rall();
    rd(8'h01, d);
    chk(18'(d & 8'h03), 18'({stat_in.trace_input_signal_loss, 1'b1}), "loss");
    rd(8'h02, d);
    chk(18'(d), 18'(stat_in.status_view), "status view");
    $display("test writes done");
    wr(8'h00, 8'h04);
    mreset();
    rall();
    wr(8'hff, 8'h05);
    rd(8'h03, d);
    chk(18'(d), 18'h0, "cable page");
    wr(8'hff, 8'h06);
    rd(8'hff, d);
    chk(18'(d), 18'h06, "page reg");
    rd(8'h03, d);
    chk(18'(d), 18'h0, "bad page");
    $display("test pages done");
    wr(8'hff, 8'h00);
    wr(8'he2, 8'h01);
    wt(1'b1);
    wt(1'b0);
    rd(8'he2, d);
    chk(18'(d[4]), 18'h1, "init done");
    $display("test init done");
    for (int v = 0; v < 16; v++) begin
      wr(8'hff, 8'(v << 4));
      repeat (4) begin
        stat_in <= spr_stat_t'($urandom);
        repeat (4) @(posedge clk_sys);
        chk(18'(lock_out), 18'(lk(8'(v << 4), stat_in)), "lock pin");
      end
    end
    $display("test lock done");
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    sys_rst <= 1'b0;
    repeat (3) @(posedge clk_sys);
    rd(8'hff, d);
    chk(18'(d), 18'h0, "page after reset");
    $display("test reset done");
    print_verdict();
  end
endmodule : spr_port_tb
`default_nettype wire
